// ### rtl/cqw_pkg.sv
// Contract
// - In array read, writing 98h to word address 55h enters query mode.
// - Query mode lasts until the reset command or a supply lockout returns to array reads.
// - The query command is also taken from identification readout mode.
// - A write cycle needs select and strobe low with output enable high.
package cqw_pkg;

    localparam int CLK_PERIOD_NS = 100;
    localparam int T_ADDR_SETUP_NS = 50;
    localparam int T_WE_LOW_NS = 50;
    localparam int T_WE_HIGH_NS = 50;
    localparam int T_READ_ACCESS_NS = 100;
    localparam int T_POWER_UP_NS = 1000;
    localparam int SYNC_CYC = 3;

    function automatic int ns_to_cyc_up(int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int WR_SETUP_CYC = ns_to_cyc_up(T_ADDR_SETUP_NS);
    localparam int WE_LOW_CYC = ns_to_cyc_up(T_WE_LOW_NS);
    localparam int WE_HIGH_CYC = ns_to_cyc_up(T_WE_HIGH_NS);
    localparam int RD_ACCESS_CYC = ns_to_cyc_up(T_READ_ACCESS_NS);
    localparam int POWER_UP_CYC = ns_to_cyc_up(T_POWER_UP_NS);

    localparam int ADDR_W = 22;
    localparam int WADDR_W = ADDR_W - 1;
    localparam int DATA_W = 16;
    localparam int TMR_W = 8;

    localparam logic [7:0] QUERY_CMD = 8'h98;
    localparam logic [WADDR_W-1:0] QUERY_CMD_ADDR = 21'h00055;
    localparam logic [WADDR_W-1:0] RESET_CMD_ADDR = 21'h00000;
    localparam logic [7:0] RESET_CMD_DEFAULT = 8'hf0;

    localparam logic [6:0] VFY_FIRST = 7'h10;
    localparam logic [6:0] VFY_SYS_LAST = 7'h26;
    localparam logic [6:0] VFY_EXT_FIRST = 7'h40;
    localparam logic [6:0] VFY_EXT_LAST = 7'h42;

    typedef enum logic [1:0] {
        CMD_READ = 2'b00,
        CMD_QUERY = 2'b01,
        CMD_RESET = 2'b10,
        CMD_VERIFY = 2'b11
    } cqw_cmd_t;

    typedef enum logic {
        MODE_ARRAY = 1'b0,
        MODE_QUERY = 1'b1
    } cqw_mode_t;

    typedef enum logic [1:0] {
        VPH_NONE = 2'b00,
        VPH_ENTER = 2'b01,
        VPH_READ = 2'b10,
        VPH_EXIT = 2'b11
    } cqw_vph_t;

    typedef enum logic [2:0] {
        ST_PWRUP = 3'b000,
        ST_IDLE = 3'b001,
        ST_WR_SETUP = 3'b010,
        ST_WR_PULSE = 3'b011,
        ST_WR_HOLD = 3'b100,
        ST_RD_ACCESS = 3'b101,
        ST_RD_SETTLE = 3'b110,
        ST_GAP = 3'b111
    } cqw_state_t;

    typedef struct packed {
        cqw_cmd_t cmd;
        logic [WADDR_W-1:0] addr;
    } cqw_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [DATA_W-1:0] data;
    } cqw_rsp_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe_n;
    } cqw_pins_t;

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic done;
    } cqw_tmr_state_t;

    typedef struct packed {
        cqw_state_t st;
        cqw_pins_t pins;
        cqw_mode_t mode;
        cqw_mode_t next_mode;
        cqw_vph_t vph;
        logic [6:0] vaddr;
        logic vlast;
        logic mismatch;
        logic wait_eq;
        logic bm;
        logic [DATA_W-1:0] dq_s1;
        logic [DATA_W-1:0] dq_s2;
        logic [DATA_W-1:0] dq_s3;
        logic lk_s1;
        logic lk_s2;
        logic lk_s3;
        logic lk_lvl;
        logic ready;
        cqw_rsp_t rsp;
        logic sig_ok;
        logic tmr_start;
        logic [TMR_W-1:0] tmr_load;
    } cqw_host_state_t;

    localparam cqw_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0,
                                        dq_out: '0, dq_oe_n: 1'b1};

    // Power-up holds every strobe high and keeps the timer running for the settle time.
    localparam cqw_host_state_t HOST_RESET = '{st: ST_PWRUP, pins: PINS_IDLE,
        mode: MODE_ARRAY, next_mode: MODE_ARRAY, vph: VPH_NONE, tmr_start: 1'b1,
        tmr_load: TMR_W'(POWER_UP_CYC), default: '0};

    // Expected query table contents; everything undefined reads zero.
    function automatic logic [DATA_W-1:0] cqw_expect(logic [6:0] a);
        logic [DATA_W-1:0] v;
        v = 16'h0000;
        unique case (a)
            7'h10: v = 16'h0051;
            7'h11: v = 16'h0052;
            7'h12: v = 16'h0059;
            7'h13: v = 16'h0002;
            7'h15: v = 16'h0040;
            7'h1b: v = 16'h0027;
            7'h1c: v = 16'h0036;
            7'h1f: v = 16'h0007;
            7'h20: v = 16'h0007;
            7'h21: v = 16'h000a;
            7'h23: v = 16'h0001;
            7'h24: v = 16'h0005;
            7'h25: v = 16'h0004;
            7'h40: v = 16'h0050;
            7'h41: v = 16'h0052;
            7'h42: v = 16'h0049;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

endpackage

// ### rtl/cqw_phase_timer.sv
`timescale 1ns/100ps
`default_nettype none
module cqw_phase_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [cqw_pkg::TMR_W-1:0] load,
    output logic done
);
    import cqw_pkg::*;

    cqw_tmr_state_t t_q;
    cqw_tmr_state_t t_d;

    // The done pulse comes in the cycle the count reaches zero, and start and done are both registered, so a phase lasts
    // load plus two cycles, which keeps every least time on the safe side.
    always_comb begin
        t_d = t_q;
        t_d.done = 1'b0;
        if (start) begin
            t_d.cnt = load;
        end else if (t_q.cnt != '0) begin
            t_d.cnt = t_q.cnt - 1'b1;
            t_d.done = (t_q.cnt == TMR_W'(1));
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end

    assign done = t_q.done;
endmodule
`default_nettype wire

// ### rtl/cqw_query_host.sv
`timescale 1ns/100ps
`default_nettype none
module cqw_query_host #(
    parameter logic [7:0] RESET_CMD = cqw_pkg::RESET_CMD_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire cqw_pkg::cqw_req_t req,
    output logic req_ready,
    output cqw_pkg::cqw_rsp_t rsp,
    input wire logic byte_mode,
    input wire logic supply_below_lockout,
    input wire logic [cqw_pkg::DATA_W-1:0] dq_in,
    output cqw_pkg::cqw_pins_t pins,
    output cqw_pkg::cqw_mode_t host_mode,
    output logic sig_ok
);
    import cqw_pkg::*;

    cqw_host_state_t q;
    cqw_host_state_t d;
    logic tmr_done;
    logic [DATA_W-1:0] rd_word;

    cqw_phase_timer u_timer (
        .clk(clk),
        .rst(rst),
        .start(q.tmr_start),
        .load(q.tmr_load),
        .done(tmr_done)
    );

    function automatic logic [ADDR_W-1:0] scale(logic [WADDR_W-1:0] wa, logic bm);
        return bm ? {wa, 1'b0} : {1'b0, wa};
    endfunction

    function automatic cqw_host_state_t start_write(cqw_host_state_t s,
                                                    logic [WADDR_W-1:0] wa,
                                                    logic [7:0] cmd);
        cqw_host_state_t r;
        r = s;
        r.st = ST_WR_SETUP;
        r.pins.ce_n = 1'b0;
        r.pins.oe_n = 1'b1;
        r.pins.we_n = 1'b1;
        r.pins.addr = scale(wa, s.bm);
        r.pins.dq_out = {8'h00, cmd};
        r.pins.dq_oe_n = 1'b0;
        r.tmr_start = 1'b1;
        r.tmr_load = TMR_W'(WR_SETUP_CYC);
        return r;
    endfunction

    function automatic cqw_host_state_t start_read(cqw_host_state_t s,
                                                   logic [WADDR_W-1:0] wa);
        cqw_host_state_t r;
        r = s;
        r.st = ST_RD_ACCESS;
        r.pins.ce_n = 1'b0;
        r.pins.oe_n = 1'b0;
        r.pins.we_n = 1'b1;
        r.pins.addr = scale(wa, s.bm);
        r.pins.dq_oe_n = 1'b1;
        r.tmr_start = 1'b1;
        r.tmr_load = TMR_W'(RD_ACCESS_CYC);
        return r;
    endfunction

    // In byte mode only the low lane carries data, so the upper byte is cleared.
    assign rd_word = q.bm ? {8'h00, q.dq_s3[7:0]} : q.dq_s3;

    always_comb begin
        d = q;
        d.tmr_start = 1'b0;
        d.rsp.valid = 1'b0;
        d.dq_s1 = dq_in;
        d.dq_s2 = q.dq_s1;
        d.dq_s3 = q.dq_s2;
        d.lk_s1 = supply_below_lockout;
        d.lk_s2 = q.lk_s1;
        d.lk_s3 = q.lk_s2;
        if (q.lk_s2 == q.lk_s3) begin
            d.lk_lvl = q.lk_s3;
        end
        unique case (q.st)
            ST_PWRUP: begin
                if (tmr_done) begin
                    d.st = ST_IDLE;
                    d.ready = 1'b1;
                end
            end
            ST_IDLE: begin
                if (req_valid && q.ready) begin
                    d.ready = 1'b0;
                    d.bm = byte_mode;
                    d.rsp.err = 1'b0;
                    if (req.cmd == CMD_READ) begin
                        d = start_read(d, req.addr);
                    end else if (q.lk_lvl) begin
                        // The device drops writes while the supply is low anyway.
                        d.rsp.valid = 1'b1;
                        d.rsp.err = 1'b1;
                        d.ready = 1'b1;
                    end else if (req.cmd == CMD_RESET) begin
                        d.next_mode = MODE_ARRAY;
                        d = start_write(d, RESET_CMD_ADDR, RESET_CMD);
                    end else begin
                        // Issued from any mode, identification readout included.
                        d.next_mode = MODE_QUERY;
                        d.mismatch = 1'b0;
                        d.vph = (req.cmd == CMD_VERIFY) ? VPH_ENTER : VPH_NONE;
                        d = start_write(d, QUERY_CMD_ADDR, QUERY_CMD);
                    end
                end
            end
            ST_WR_SETUP: begin
                if (tmr_done) begin
                    d.st = ST_WR_PULSE;
                    d.pins.we_n = 1'b0;
                    d.tmr_start = 1'b1;
                    d.tmr_load = TMR_W'(WE_LOW_CYC);
                end
            end
            ST_WR_PULSE: begin
                if (tmr_done) begin
                    d.st = ST_WR_HOLD;
                    d.pins.we_n = 1'b1;
                    d.tmr_start = 1'b1;
                    d.tmr_load = TMR_W'(WE_HIGH_CYC);
                end
            end
            ST_WR_HOLD: begin
                if (tmr_done) begin
                    d.st = ST_GAP;
                    d.pins = PINS_IDLE;
                    d.mode = q.next_mode;
                end
            end
            ST_RD_ACCESS: begin
                if (tmr_done) begin
                    d.st = ST_RD_SETTLE;
                    d.wait_eq = 1'b0;
                    d.tmr_start = 1'b1;
                    d.tmr_load = TMR_W'(SYNC_CYC);
                end
            end
            ST_RD_SETTLE: begin
                if (tmr_done) begin
                    d.wait_eq = 1'b1;
                end
                // A word counts only once two synchroniser stages agree.
                if (q.wait_eq && (q.dq_s2 == q.dq_s3)) begin
                    d.st = ST_GAP;
                    d.pins = PINS_IDLE;
                    d.rsp.data = rd_word;
                    if (q.vph == VPH_READ) begin
                        d.mismatch = q.mismatch | (rd_word != cqw_expect(q.vaddr));
                        d.vlast = (q.vaddr == VFY_EXT_LAST);
                        d.vaddr = (q.vaddr == VFY_SYS_LAST) ? VFY_EXT_FIRST :
                                  7'(q.vaddr + 7'h01);
                    end
                end
            end
            ST_GAP: begin
                if (q.vph == VPH_ENTER) begin
                    d.vph = VPH_READ;
                    d.vaddr = VFY_FIRST;
                    d.vlast = 1'b0;
                    d = start_read(d, {14'h0000, VFY_FIRST});
                end else if (q.vph == VPH_READ && !q.vlast) begin
                    d = start_read(d, {14'h0000, q.vaddr});
                end else if (q.vph == VPH_READ) begin
                    d.vph = VPH_EXIT;
                    d.next_mode = MODE_ARRAY;
                    d = start_write(d, RESET_CMD_ADDR, RESET_CMD);
                end else begin
                    if (q.vph == VPH_EXIT) begin
                        d.sig_ok = !q.mismatch;
                        d.rsp.err = q.mismatch;
                    end
                    d.vph = VPH_NONE;
                    d.st = ST_IDLE;
                    d.rsp.valid = 1'b1;
                    d.ready = 1'b1;
                end
            end
        endcase
        // The device falls back to read mode under lockout, so the tracker follows.
        if (d.lk_lvl) begin
            d.mode = MODE_ARRAY;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= HOST_RESET;
        end else begin
            q <= d;
        end
    end

    assign req_ready = q.ready;
    assign rsp = q.rsp;
    assign pins = q.pins;
    assign host_mode = q.mode;
    assign sig_ok = q.sig_ok;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_QUERY_ADDR: assert property (
        $rose(q.pins.we_n) && q.pins.dq_out[7:0] == QUERY_CMD
        |-> q.pins.addr == scale(QUERY_CMD_ADDR, q.bm))
        else $error("query command written to wrong address");
    AST_QUERY_ENTRY: assert property (
        $rose(q.mode == MODE_QUERY)
        |-> $past(q.st) == ST_WR_HOLD && $past(q.pins.dq_out[7:0]) == QUERY_CMD)
        else $error("query mode entered without query command");
    AST_RESET_EXIT: assert property (
        $fell(q.mode == MODE_QUERY) && !q.lk_lvl
        |-> $past(q.pins.dq_out[7:0]) == RESET_CMD)
        else $error("query mode left without reset command");
    AST_WE_QUAL: assert property (
        !q.pins.we_n |-> !q.pins.ce_n && q.pins.oe_n && !q.pins.dq_oe_n)
        else $error("write strobe low without select low and output enable high");
    AST_DRIVE_QUAL: assert property (
        !q.pins.dq_oe_n |-> q.pins.oe_n)
        else $error("data driven while output enable low");
    AST_PULSE_BOUND: assert property (
        $fell(q.pins.we_n) |-> !q.pins.we_n [*2] ##[1:20] $rose(q.pins.we_n))
        else $error("write pulse too short or not ended");
    AST_PWRUP_QUIET: assert property (
        q.st == ST_PWRUP |-> q.pins.ce_n && q.pins.we_n && q.pins.oe_n)
        else $error("control lines active during power-up");
    AST_PWRUP_MODE: assert property (
        q.st == ST_PWRUP |-> q.mode == MODE_ARRAY && q.vph == VPH_NONE)
        else $error("power-up not in read mode");
    AST_LOCKOUT_REFUSE: assert property (
        q.lk_lvl && q.st == ST_IDLE |=> q.st != ST_WR_SETUP)
        else $error("write started under supply lockout");
endmodule
`default_nettype wire

// ### test/cqw_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module cqw_flash_model #(
    parameter logic [7:0] RESET_OP = 8'hf0
) (
    input wire logic pwr_up,
    input wire logic below_lockout,
    input wire logic byte_mode,
    input wire logic ident_set,
    input wire cqw_pkg::cqw_pins_t pins,
    output logic [15:0] dq,
    output logic [1:0] mode,
    output logic [7:0] wr_count,
    output logic [7:0] viol
);
    import cqw_pkg::*;
    localparam logic [15:0] QTAB [0:25] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000,
        16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036,
        16'h0000, 16'h0000, 16'h0007, 16'h0007, 16'h000a, 16'h0000, 16'h0001, 16'h0005,
        16'h0004, 16'h0000, 16'h0050, 16'h0052, 16'h0049};
    logic [20:0] wa;
    logic [15:0] val;
    logic [15:0] last_q;
    logic drive;
    assign wa = byte_mode ? pins.addr[21:1] : pins.addr[20:0];
    assign drive = !pins.ce_n && !pins.oe_n;
    // A released bus shows the inverse of the last word so stale data never matches.
    assign dq = drive ? val : ~last_q;
    always_comb begin
        val = {wa[7:0], ~wa[7:0]};
        if (mode == 2'd2) begin
            val = 16'h0001;
        end else if (mode == 2'd1) begin
            val = 16'h0000;
            if (wa >= 21'h10 && wa <= 21'h26) begin
                val = QTAB[wa - 21'h10];
            end else if (wa >= 21'h40 && wa <= 21'h42) begin
                val = QTAB[wa - 21'h29];
            end
        end
    end
    // Each output has one owning process, so every value has exactly one driver.
    initial begin
        last_q = 16'h0000;
        forever begin
            @(val or drive);
            if (drive) begin
                last_q = val;
            end
        end
    end
    initial begin
        mode = 2'd0;
        wr_count = 8'h00;
        forever begin
            @(posedge pins.we_n or posedge below_lockout or posedge pwr_up or posedge ident_set);
            if (pwr_up || below_lockout) begin
                mode = 2'd0;
            end else if (ident_set) begin
                mode = 2'd2;
            end else if (!pins.ce_n && pins.oe_n) begin
                wr_count = wr_count + 8'h01;
                if (pins.dq_out[7:0] == 8'h98 && wa == 21'h55) begin
                    mode = 2'd1;
                end else if (pins.dq_out[7:0] == RESET_OP) begin
                    mode = 2'd0;
                end
            end
        end
    end
    initial begin
        viol = 8'h00;
        forever begin
            @(negedge pins.we_n or negedge pins.oe_n);
            if (!pins.we_n && !pins.oe_n) begin
                viol = viol + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cqw_pkg::*;
    localparam logic [15:0] QEXP [0:25] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000,
        16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036,
        16'h0000, 16'h0000, 16'h0007, 16'h0007, 16'h000a, 16'h0000, 16'h0001, 16'h0005,
        16'h0004, 16'h0000, 16'h0050, 16'h0052, 16'h0049};
    logic clk, rst, req_valid, req_ready, byte_mode, lockout, ident_set, sig_ok;
    cqw_req_t req;
    cqw_rsp_t rsp, got;
    cqw_pins_t pins;
    cqw_mode_t host_mode;
    logic [15:0] dq;
    logic [1:0] fmode;
    logic [7:0] wr_count, viol, w0;
    int bad_count, checked;

    cqw_query_host dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp(rsp), .byte_mode(byte_mode),
        .supply_below_lockout(lockout), .dq_in(dq), .pins(pins), .host_mode(host_mode),
        .sig_ok(sig_ok));
    cqw_flash_model flash_u (.pwr_up(rst), .below_lockout(lockout), .byte_mode(byte_mode),
        .ident_set(ident_set), .pins(pins), .dq(dq), .mode(fmode), .wr_count(wr_count),
        .viol(viol));

    initial clk = 1'b0;
    always #50 clk = ~clk;

    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask

    task automatic do_req(input cqw_cmd_t c, input logic [20:0] a);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req = '{cmd: c, addr: a};
        n = 0;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp.valid !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk1(rsp.valid, 1'b1);
        got = rsp;
    endtask

    task automatic end_sim();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic t_query_word();
        do_req(CMD_READ, 21'h10);
        chk16(got.data, 16'h10ef);
        w0 = wr_count;
        do_req(CMD_QUERY, 21'h55);
        chk16({8'h00, wr_count}, {8'h00, w0 + 8'h01});
        chk16({14'h0000, fmode}, 16'h0001);
        chk1(host_mode, 1'b1);
        for (int i = 0; i < 26; i++) begin
            do_req(CMD_READ, (i < 23) ? 21'(16 + i) : 21'(41 + i));
            chk16(got.data, QEXP[i]);
        end
        do_req(CMD_READ, 21'h27);
        chk16(got.data, 16'h0000);
        do_req(CMD_RESET, 21'h0);
        chk16({14'h0000, fmode}, 16'h0000);
        chk1(host_mode, 1'b0);
        do_req(CMD_READ, 21'h11);
        chk16(got.data, 16'h11ee);
        $display("test query_word done");
    endtask

    task automatic t_byte();
        @(negedge clk);
        byte_mode = 1'b1;
        do_req(CMD_QUERY, 21'h55);
        chk16({14'h0000, fmode}, 16'h0001);
        do_req(CMD_READ, 21'h12);
        chk16(got.data, 16'h0059);
        do_req(CMD_READ, 21'h40);
        chk16(got.data, 16'h0050);
        do_req(CMD_RESET, 21'h0);
        chk16({14'h0000, fmode}, 16'h0000);
        do_req(CMD_READ, 21'h12);
        chk16(got.data, 16'h00ed);
        @(negedge clk);
        byte_mode = 1'b0;
        $display("test byte done");
    endtask

    task automatic t_ident();
        @(negedge clk);
        ident_set = 1'b1;
        @(negedge clk);
        ident_set = 1'b0;
        do_req(CMD_QUERY, 21'h55);
        chk16({14'h0000, fmode}, 16'h0001);
        do_req(CMD_READ, 21'h11);
        chk16(got.data, 16'h0052);
        do_req(CMD_RESET, 21'h0);
        chk16({14'h0000, fmode}, 16'h0000);
        $display("test ident done");
    endtask

    task automatic t_lockout();
        @(negedge clk);
        lockout = 1'b1;
        repeat (6) @(negedge clk);
        w0 = wr_count;
        do_req(CMD_QUERY, 21'h55);
        chk1(got.err, 1'b1);
        chk16({8'h00, wr_count}, {8'h00, w0});
        chk1(host_mode, 1'b0);
        do_req(CMD_READ, 21'h12);
        chk16(got.data, 16'h12ed);
        lockout = 1'b0;
        repeat (6) @(negedge clk);
        do_req(CMD_QUERY, 21'h55);
        chk1(host_mode, 1'b1);
        lockout = 1'b1;
        repeat (8) @(negedge clk);
        chk1(host_mode, 1'b0);
        chk16({14'h0000, fmode}, 16'h0000);
        lockout = 1'b0;
        repeat (6) @(negedge clk);
        $display("test lockout done");
    endtask

    task automatic t_power();
        do_req(CMD_QUERY, 21'h55);
        chk16({14'h0000, fmode}, 16'h0001);
        @(negedge clk);
        rst = 1'b1;
        repeat (8) @(negedge clk);
        chk16({14'h0000, fmode}, 16'h0000);
        chk1(host_mode, 1'b0);
        chk1(req_ready, 1'b0);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk1(req_ready, 1'b0);
        chk1(pins.ce_n & pins.we_n & pins.oe_n, 1'b1);
        do_req(CMD_READ, 21'h13);
        chk16(got.data, 16'h13ec);
        $display("test power done");
    endtask

    task automatic t_verify();
        do_req(CMD_VERIFY, 21'h0);
        chk1(sig_ok, 1'b1);
        chk1(got.err, 1'b0);
        chk16(got.data, 16'h0049);
        chk1(host_mode, 1'b0);
        chk16({8'h00, viol}, 16'h0000);
        $display("test verify done");
    endtask

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        byte_mode = 1'b0;
        lockout = 1'b0;
        ident_set = 1'b0;
        bad_count = 0;
        checked = 0;
        repeat (8) @(negedge clk);
        chk1(pins.ce_n & pins.we_n & pins.oe_n, 1'b1);
        chk1(req_ready, 1'b0);
        chk16({14'h0000, fmode}, 16'h0000);
        rst = 1'b0;
        $display("test reset done");
        t_query_word();
        t_byte();
        t_ident();
        t_lockout();
        t_power();
        t_verify();
        end_sim();
    end

    // The tests need about a thousand cycles; this bound of 20000 cycles leaves wide margin.
    initial begin
        #2000000;
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
